// ### pkee_engine.sv
// Overview of operation
// - prime-field curve arithmetic for 192-bit and 256-bit operands
// - parameter sets for p192, p256, X25519 and EdDSA loaded as operands
// - whole modular add, subtract and doubling programs run from microcode without processor help
// - progress and completion seen by polling status or the interrupt output
// - microcode store, instruction unit, 32-bit ALU, two data rams, register block
// - calculations are microcode sequences in a 2 KB program store
// - operands and control/status registers share one host window
// - multi-word operands keep least significant word at lowest address
// - start command begins a run; status stays readable throughout
// - halt via control register abandons the running operation
// - intermediate results stay in host-readable ram slots
// - data ram access is aligned whole words only
// - first ram decoded from 0x400, second ram from 0x1000
// - ten operand slots in each of the two rams
// - slot n starts at ram base plus n times the layout stride
// - extra internal ram space beyond the slots is not host reachable
// - launch bit starts next cycle using settings held in the write cycle
// - halt bit stops the engine on the next cycle
// - irq_gate only gates the interrupt output, never the status
// - word-count field sets working width to count times 32 bits, or the layout's full width when zero
`timescale 1ns/10ps
`default_nettype none
module pkee_engine
    import pkee_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq_out
);
    typedef enum logic [2:0] {R_NONE, R_RAMA, R_RAMB, R_CTRL, R_CFG, R_MODE, R_STAT} pkee_region_t;
    typedef enum {S_IDLE, S_FETCH, S_DECODE, S_READ, S_EXEC} pkee_state_t;

    // one decode for read setup and write access alike
    function automatic pkee_region_t region(input logic [ADDR_W-1:0] a);
        if (a[1:0] != 2'h0) begin
            region = R_NONE;
        end else if (a >= RAMA_BASE && a <= RAMA_LAST) begin
            region = R_RAMA;
        end else if (a >= RAMB_BASE && a <= RAMB_LAST) begin
            region = R_RAMB;
        end else if (a == CTRL_OFS) begin
            region = R_CTRL;
        end else if (a == CFG_OFS) begin
            region = R_CFG;
        end else if (a == MODE_OFS) begin
            region = R_MODE;
        end else if (a == STAT_OFS) begin
            region = R_STAT;
        end else begin
            region = R_NONE;
        end
    endfunction

    // slot n begins at n strides from the ram start
    function automatic logic [9:0] slot_base(input logic [1:0] sel, input logic [3:0] n);
        logic [9:0] stride;
        stride = (sel == 2'h0) ? STRIDE_256 : (sel == 2'h1) ? STRIDE_512 : STRIDE_1024;
        slot_base = 10'(stride * n);
    endfunction

    function automatic logic [31:0] mk(input pkee_uop_t op, input logic [3:0] d, input logic [3:0] a,
                                       input logic [3:0] b, input logic [8:0] t);
        mk = {op, d, a, b, 7'h00, t};
    endfunction

    // program store; unused words decode as end of program
    function automatic logic [31:0] urom(input logic [UROM_AW-1:0] pc);
        case (pc)
            // modular add: A2 = A0 + B0 mod B1
            9'h000: urom = mk(UOP_ADD, 4'h2, 4'h0, 4'h0, 9'h000);
            9'h001: urom = mk(UOP_SUB, 4'h3, 4'h2, 4'h1, 9'h000);
            9'h002: urom = mk(UOP_JC, 4'h0, 4'h0, 4'h0, 9'h005);
            9'h003: urom = mk(UOP_MOVA, 4'h2, 4'h3, 4'h0, 9'h000);
            9'h004: urom = mk(UOP_MOVB, 4'h2, 4'h0, 4'h2, 9'h000);
            // modular subtract: A2 = A0 - B0 mod B1
            9'h010: urom = mk(UOP_SUB, 4'h2, 4'h0, 4'h0, 9'h000);
            9'h011: urom = mk(UOP_JNC, 4'h0, 4'h0, 4'h0, 9'h013);
            9'h012: urom = mk(UOP_ADD, 4'h2, 4'h2, 4'h1, 9'h000);
            // modular doubling: A2 = 2*A0 mod B1, single pass with A0 first copied to B4
            9'h020: urom = mk(UOP_MOVA, 4'h4, 4'h0, 4'h0, 9'h000);
            9'h021: urom = mk(UOP_ADD, 4'h2, 4'h0, 4'h4, 9'h000);
            9'h022: urom = mk(UOP_SUB, 4'h3, 4'h2, 4'h1, 9'h000);
            9'h023: urom = mk(UOP_JC, 4'h0, 4'h0, 4'h0, 9'h026);
            9'h024: urom = mk(UOP_MOVA, 4'h2, 4'h3, 4'h0, 9'h000);
            9'h025: urom = mk(UOP_MOVB, 4'h2, 4'h0, 4'h2, 9'h000);
            default: urom = 32'h0000_0000;
        endcase
    endfunction

    logic setup;
    logic access;
    pkee_region_t cur_region;
    logic wr_acc;
    pkee_region_t rd_src;
    logic [31:0] reg_rdata;
    logic irq_gate;
    logic [7:0] part_words;
    logic [1:0] base_width_select;
    logic [1:0] op_select;
    logic go_pulse;
    logic halt_pulse;
    logic [7:0] run_words;
    logic [1:0] run_base;
    logic [1:0] run_op;
    pkee_state_t state;
    logic busy;
    logic done;
    logic halted;
    logic carry;
    logic [UROM_AW-1:0] upc;
    logic [31:0] uword;
    logic [7:0] widx;
    pkee_uop_t uop;
    logic [3:0] f_dst;
    logic [3:0] f_a;
    logic [3:0] f_b;
    logic [8:0] f_tgt;
    pkee_ram_req_t host_a_req;
    pkee_ram_req_t host_b_req;
    pkee_ram_req_t eng_a_req;
    pkee_ram_req_t eng_b_req;
    logic [31:0] host_a_q;
    logic [31:0] host_b_q;
    logic [31:0] eng_a_q;
    logic [31:0] eng_b_q;
    logic [32:0] alu_sum;
    logic [32:0] alu_dif;
    logic last_word;
    logic [7:0] eff_words;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign cur_region = region(paddr);
    assign wr_acc = access & pwrite;

    // zero wait states: ram reads are issued in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access & (cur_region == R_NONE);
    assign prdata = (rd_src == R_RAMA) ? host_a_q : (rd_src == R_RAMB) ? host_b_q : reg_rdata;

    // host ram ports; word index counts from the ram's own base
    always_comb begin
        host_a_req.addr = 10'((paddr - RAMA_BASE) >> 2);
        host_a_req.wdata = pwdata;
        host_a_req.we = wr_acc & (cur_region == R_RAMA);
        host_b_req.addr = 10'((paddr - RAMB_BASE) >> 2);
        host_b_req.wdata = pwdata;
        host_b_req.we = wr_acc & (cur_region == R_RAMB);
    end

    // read source and register data captured at setup, held through access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_src <= R_NONE;
            reg_rdata <= 32'h0000_0000;
        end else if (setup) begin
            rd_src <= cur_region;
            case (cur_region)
                R_CFG: reg_rdata <= {8'h00, part_words, 7'h00, irq_gate, 8'h00};
                R_MODE: reg_rdata <= {26'h0, op_select, 2'h0, base_width_select};
                R_STAT: reg_rdata <= {7'h00, upc, 12'h000, carry, halted, done, busy};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // software settings
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_gate <= 1'b0;
            part_words <= PART_RST;
            base_width_select <= BASE_RST;
            op_select <= OPSEL_RST;
        end else if (wr_acc && cur_region == R_CFG) begin
            irq_gate <= pwdata[IRQ_GATE_BIT];
            part_words <= pwdata[PART_LSB +: 8];
        end else if (wr_acc && cur_region == R_MODE) begin
            base_width_select <= pwdata[BASE_LSB +: 2];
            op_select <= pwdata[OPSEL_LSB +: 2];
        end
    end

    // launch and halt are write-one pulses acted on one cycle later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            go_pulse <= 1'b0;
            halt_pulse <= 1'b0;
        end else begin
            go_pulse <= wr_acc & (cur_region == R_CTRL) & pwdata[GO_BIT];
            halt_pulse <= wr_acc & (cur_region == R_CTRL) & pwdata[HALT_BIT];
        end
    end

    // settings snapshot taken in the launch write cycle, not later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_words <= 8'h00;
            run_base <= 2'h0;
            run_op <= 2'h0;
        end else if (wr_acc && cur_region == R_CTRL && pwdata[GO_BIT] && !busy) begin
            run_words <= part_words;
            run_base <= base_width_select;
            run_op <= op_select;
        end
    end

    // zero count means the full width of the chosen layout
    always_comb begin
        if (run_words != 8'h00) begin
            eff_words = run_words;
        end else if (run_base == 2'h0) begin
            eff_words = WORDS_256;
        end else if (run_base == 2'h1) begin
            eff_words = WORDS_512;
        end else begin
            eff_words = WORDS_1024;
        end
    end

    assign busy = (state != S_IDLE);
    assign uop = pkee_uop_t'(uword[31:28]);
    assign f_dst = uword[27:24];
    assign f_a = uword[23:20];
    assign f_b = uword[19:16];
    assign f_tgt = uword[8:0];
    assign last_word = (widx == 8'(eff_words - 8'h01));

    // word-serial 32-bit alu, carry/borrow chained across words
    assign alu_sum = {1'b0, eng_a_q} + {1'b0, eng_b_q} + {32'h0, carry};
    assign alu_dif = {1'b0, eng_a_q} - {1'b0, eng_b_q} - {32'h0, carry};

    // engine ram ports; every slot the engine reaches lies inside the host range
    always_comb begin
        eng_a_req.addr = 10'(slot_base(run_base, f_a) + {2'h0, widx});
        eng_b_req.addr = 10'(slot_base(run_base, f_b) + {2'h0, widx});
        eng_a_req.we = 1'b0;
        eng_b_req.we = 1'b0;
        eng_a_req.wdata = 32'h0000_0000;
        eng_b_req.wdata = 32'h0000_0000;
        if (state == S_EXEC) begin
            unique case (uop)
                UOP_ADD: begin
                    eng_a_req.addr = 10'(slot_base(run_base, f_dst) + {2'h0, widx});
                    eng_a_req.we = 1'b1;
                    eng_a_req.wdata = alu_sum[31:0];
                end
                UOP_SUB: begin
                    eng_a_req.addr = 10'(slot_base(run_base, f_dst) + {2'h0, widx});
                    eng_a_req.we = 1'b1;
                    eng_a_req.wdata = alu_dif[31:0];
                end
                UOP_MOVA: begin
                    eng_b_req.addr = 10'(slot_base(run_base, f_dst) + {2'h0, widx});
                    eng_b_req.we = 1'b1;
                    eng_b_req.wdata = eng_a_q;
                end
                UOP_MOVB: begin
                    eng_a_req.addr = 10'(slot_base(run_base, f_dst) + {2'h0, widx});
                    eng_a_req.we = 1'b1;
                    eng_a_req.wdata = eng_b_q;
                end
                default: begin
                    eng_a_req.we = 1'b0;
                end
            endcase
        end
    end

    // microcode instruction unit; halt overrides everything
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            upc <= 9'h000;
            uword <= 32'h0000_0000;
            widx <= 8'h00;
            carry <= 1'b0;
        end else if (halt_pulse) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (go_pulse) begin
                        state <= S_FETCH;
                        carry <= 1'b0;
                        upc <= (run_op == 2'h0) ? ENTRY_MODADD : (run_op == 2'h1) ? ENTRY_MODSUB :
                               (run_op == 2'h2) ? ENTRY_OP2 : ENTRY_OP3;
                    end
                end
                S_FETCH: begin
                    uword <= urom(upc);
                    state <= S_DECODE;
                end
                S_DECODE: begin
                    widx <= 8'h00;
                    unique case (uop)
                        UOP_END: state <= S_IDLE;
                        UOP_JMP: begin
                            upc <= f_tgt;
                            state <= S_FETCH;
                        end
                        UOP_JC: begin
                            upc <= carry ? f_tgt : 9'(upc + 9'h001);
                            state <= S_FETCH;
                        end
                        UOP_JNC: begin
                            upc <= carry ? 9'(upc + 9'h001) : f_tgt;
                            state <= S_FETCH;
                        end
                        UOP_ADD, UOP_SUB, UOP_MOVA, UOP_MOVB: begin
                            carry <= 1'b0;
                            state <= S_READ;
                        end
                        default: state <= S_IDLE;
                    endcase
                end
                S_READ: state <= S_EXEC;
                S_EXEC: begin
                    if (uop == UOP_ADD) begin
                        carry <= alu_sum[32];
                    end else if (uop == UOP_SUB) begin
                        carry <= alu_dif[32];
                    end
                    widx <= 8'(widx + 8'h01);
                    if (last_word) begin
                        upc <= 9'(upc + 9'h001);
                        state <= S_FETCH;
                    end else begin
                        state <= S_READ;
                    end
                end
            endcase
        end
    end

    // completion flags stay until the next launch so polling cannot miss them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            halted <= 1'b0;
        end else if (busy && halt_pulse) begin
            halted <= 1'b1;
        end else if (state == S_DECODE && uop == UOP_END) begin
            done <= 1'b1;
        end else if (state == S_IDLE && go_pulse) begin
            done <= 1'b0;
            halted <= 1'b0;
        end
    end

    // gate only reaches the pin; status above never looks at it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_gate & done;
        end
    end

    pkee_dpram u_ram_a (
        .clk_sys(clk_sys),
        .host_req(host_a_req),
        .eng_req(eng_a_req),
        .host_q(host_a_q),
        .eng_q(eng_a_q)
    );

    pkee_dpram u_ram_b (
        .clk_sys(clk_sys),
        .host_req(host_b_req),
        .eng_req(eng_b_req),
        .host_q(host_b_q),
        .eng_q(eng_b_q)
    );
endmodule
`default_nettype wire

// ### pkee_pkg.sv
package pkee_pkg;
    // host address map, byte offsets
    localparam int unsigned ADDR_W = 14;
    localparam logic [13:0] RAMA_BASE = 14'h0400;
    localparam logic [13:0] RAMA_LAST = 14'h0fff;
    localparam logic [13:0] RAMB_BASE = 14'h1000;
    localparam logic [13:0] RAMB_LAST = 14'h1bff;
    localparam logic [13:0] CTRL_OFS = 14'h2000;
    localparam logic [13:0] CFG_OFS = 14'h2004;
    localparam logic [13:0] MODE_OFS = 14'h2008;
    localparam logic [13:0] STAT_OFS = 14'h200c;
    // field positions
    localparam int unsigned GO_BIT = 0;
    localparam int unsigned HALT_BIT = 16;
    localparam int unsigned IRQ_GATE_BIT = 8;
    localparam int unsigned PART_LSB = 16;
    localparam int unsigned BASE_LSB = 0;
    localparam int unsigned OPSEL_LSB = 4;
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_DONE = 1;
    localparam int unsigned ST_HALTED = 2;
    localparam int unsigned ST_CARRY = 3;
    localparam int unsigned ST_UPC_LSB = 16;
    // reset values
    localparam logic [7:0] PART_RST = 8'h00;
    localparam logic [1:0] BASE_RST = 2'h0;
    localparam logic [1:0] OPSEL_RST = 2'h0;
    // data ram geometry: 768 host words, the rest internal scratch
    localparam int unsigned RAM_AW = 10;
    localparam int unsigned RAM_DEPTH = 1024;
    // slot stride in words and base word count per layout
    localparam logic [9:0] STRIDE_256 = 10'h009;
    localparam logic [9:0] STRIDE_512 = 10'h011;
    localparam logic [9:0] STRIDE_1024 = 10'h021;
    localparam logic [7:0] WORDS_256 = 8'h08;
    localparam logic [7:0] WORDS_512 = 8'h10;
    localparam logic [7:0] WORDS_1024 = 8'h20;
    // microcode store: 512 words of 32 bits, 2 KB
    localparam int unsigned UROM_AW = 9;
    localparam logic [8:0] ENTRY_MODADD = 9'h000;
    localparam logic [8:0] ENTRY_MODSUB = 9'h010;
    localparam logic [8:0] ENTRY_OP2 = 9'h020;
    localparam logic [8:0] ENTRY_OP3 = 9'h030;

    typedef enum logic [3:0] {
        UOP_END, UOP_ADD, UOP_SUB, UOP_MOVA, UOP_MOVB, UOP_JMP, UOP_JC, UOP_JNC
    } pkee_uop_t;

    typedef struct packed {
        logic we;
        logic [9:0] addr;
        logic [31:0] wdata;
    } pkee_ram_req_t;
endpackage

// ### pkee_dpram.sv
`timescale 1ns/10ps
`default_nettype none
module pkee_dpram
    import pkee_pkg::*;
(
    input wire logic clk_sys,
    input wire pkee_ram_req_t host_req,
    input wire pkee_ram_req_t eng_req,
    output logic [31:0] host_q,
    output logic [31:0] eng_q
);
    logic [31:0] mem [RAM_DEPTH];

    // both ports write from one process; on a clash the engine wins
    always_ff @(posedge clk_sys) begin
        if (host_req.we) begin
            mem[host_req.addr] <= host_req.wdata;
        end
        if (eng_req.we) begin
            mem[eng_req.addr] <= eng_req.wdata;
        end
    end

    // registered read data, old contents on a same-edge write
    always_ff @(posedge clk_sys) begin
        host_q <= mem[host_req.addr];
        eng_q <= mem[eng_req.addr];
    end
endmodule
`default_nettype wire

// ### pkee_engine_props.sv
`timescale 1ns/10ps
`default_nettype none
module pkee_engine_props
    import pkee_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_out
);
    // access phase and the decoded places the host touches
    logic acc;
    logic rd_stat;
    logic cfg_off;
    assign acc = psel & penable;
    assign rd_stat = acc & ~pwrite & (paddr == STAT_OFS);
    assign cfg_off = acc & pwrite & (paddr == CFG_OFS) & ~pwdata[IRQ_GATE_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ready_zero_wait: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_err_only_access: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access phase");
    a_err_misaligned: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_misaligned_zero: assert property (acc && !pwrite && paddr[1:0] != 2'h0 |-> prdata == 32'h0)
        else $error("misaligned read returned data");
    a_err_low_hole: assert property (acc && paddr < RAMA_BASE |-> pslverr)
        else $error("address below first ram accepted");
    a_ram_window_ok: assert property (acc && paddr[1:0] == 2'h0
        && paddr >= RAMA_BASE && paddr <= RAMB_LAST |-> !pslverr)
        else $error("ram word refused");
    a_scratch_hidden: assert property (acc && paddr > RAMB_LAST && paddr < CTRL_OFS |-> pslverr)
        else $error("internal scratch reachable");
    a_go_reads_zero: assert property (acc && !pwrite && paddr == CTRL_OFS |-> !prdata[GO_BIT])
        else $error("launch bit reads back set");
    a_gate_off_quiet: assert property (cfg_off |-> ##2 !irq_out)
        else $error("irq_out high with gate cleared");
    a_busy_done_apart: assert property (rd_stat |-> !(prdata[ST_BUSY] && prdata[ST_DONE]))
        else $error("busy and done both set");
endmodule
bind pkee_engine pkee_engine_props u_pkee_engine_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out(irq_out));
`default_nettype wire

// ### pkee_host.sv
`timescale 1ns/10ps
`default_nettype none
module pkee_host
    import pkee_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] prdata,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata
);
    // expected outcome of each transfer, oldest first: {err, mask, data}
    logic [64:0] notes[$];
    logic hang;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        hang = 1'b0;
    end

    // one whole 32-bit word per transfer, held until pready is seen
    task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
        input logic [64:0] nt, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        notes.push_back(nt);
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        hang <= (n == 64);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep showing the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic e);
        logic [31:0] q;
        xfer(1'b1, a, d, {e, 64'h0}, q);
    endtask

    task automatic rd(input logic [13:0] a, input logic [31:0] x, input logic [31:0] m,
        input logic e, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, {e, m, x}, q);
    endtask
endmodule
`default_nettype wire

// ### test_pkee_engine.sv
`timescale 1ns/10ps
`default_nettype none
module test_pkee_engine;
    import pkee_pkg::*;
    logic clk_sys;
    logic rst_n;
    logic psel, penable, pwrite, pready, pslverr, irq_out;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [64:0] nt;
    logic [31:0] sv[20];
    logic [13:0] bad[5] = '{14'h0000, 14'h03fc, 14'h0402, 14'h1c00, 14'h1ffc};
    int fails;
    int checks;

    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;

    pkee_engine u_pkee_engine (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_out(irq_out));
    pkee_host u_pkee_host (.clk_sys(clk_sys), .prdata(prdata), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // each finished transfer is matched with the oldest note
    always @(posedge clk_sys) begin
        if ((psel & penable & pready) === 1'b1) begin
            nt = u_pkee_host.notes.pop_front();
            check(prdata & nt[63:32], nt[31:0] & nt[63:32]);
            check({31'h0, pslverr}, {31'h0, nt[64]});
        end
    end

    // hang guards: a stuck handshake or an overlong run ends the test
    always @(posedge u_pkee_host.hang) begin
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end

    function automatic logic [13:0] slot(input logic [13:0] base, input int lay, input int n);
        logic [9:0] s;
        s = (lay == 0) ? STRIDE_256 : (lay == 1) ? STRIDE_512 : STRIDE_1024;
        return base + 14'(n * s * 4);
    endfunction

    // lowest word first, top word zero as padding
    task automatic put(input logic [13:0] a, input logic [95:0] x);
        for (int i = 0; i < 3; i++)
            u_pkee_host.wr(a + 14'(4 * i), x[32 * i +: 32], 1'b0);
    endtask

    // status lands two edges after the launch write, so poll from there
    task automatic wait_stat(input int k, input logic want);
        int i;
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < 400; i++) begin
            u_pkee_host.rd(STAT_OFS, 32'h0, 32'h0, 1'b0, v);
            if (v[k] === want)
                break;
        end
        if (i == 400) begin
            fails++;
            report_and_stop();
        end
    endtask

    task automatic run_op(input int op, input int lay);
        logic [95:0] a, b, m, r, s;
        logic [13:0] d;
        m = {32'h0, 1'b1, 31'($urandom), 32'($urandom)};
        a = {33'h0, 31'($urandom), 32'($urandom)};
        b = {33'h0, 31'($urandom), 32'($urandom)};
        s = (op == 0) ? a + b : (op == 1) ? a - b + m : a + a;
        r = (op == 1) ? ((a >= b) ? a - b : s) : ((s >= m) ? s - m : s);
        d = slot(RAMA_BASE, lay, 2);
        put(RAMA_BASE, a);
        put(RAMB_BASE, b);
        put(slot(RAMB_BASE, lay, 1), m);
        u_pkee_host.wr(d + 14'hc, 32'h5a5a5a5a, 1'b0);
        // settings written before the launch word
        u_pkee_host.wr(CFG_OFS, 32'h00030000, 1'b0);
        u_pkee_host.wr(MODE_OFS, 32'(op * 16 + lay), 1'b0);
        u_pkee_host.wr(CTRL_OFS, 32'h1, 1'b0);
        wait_stat(ST_DONE, 1'b1);
        for (int i = 0; i < 3; i++)
            u_pkee_host.rd(d + 14'(4 * i), r[32 * i +: 32], '1, 1'b0, v);
        u_pkee_host.rd(d + 14'hc, 32'h5a5a5a5a, '1, 1'b0, v);
    endtask

    initial begin
        rst_n = 1'b0;
        fails = 0;
        checks = 0;
        void'($urandom(23));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values of the control side
        u_pkee_host.rd(CFG_OFS, 32'h0, '1, 1'b0, v);
        u_pkee_host.rd(MODE_OFS, 32'h0, 32'h33, 1'b0, v);
        u_pkee_host.rd(STAT_OFS, 32'h0, 32'h7, 1'b0, v);
        u_pkee_host.rd(CTRL_OFS, 32'h0, 32'h1, 1'b0, v);
        foreach (bad[i])
            u_pkee_host.rd(bad[i], 32'h0, '1, 1'b1, v);
        // misaligned write must leave the word alone
        sv[0] = $urandom;
        u_pkee_host.wr(RAMA_BASE, sv[0], 1'b0);
        u_pkee_host.wr(RAMA_BASE + 14'h1, ~sv[0], 1'b1);
        u_pkee_host.rd(RAMA_BASE, sv[0], '1, 1'b0, v);
        // every slot of both rams at the widest stride, plus the second ram's last word
        for (int i = 0; i < 20; i++) begin
            sv[i] = $urandom;
            u_pkee_host.wr(slot(i < 10 ? RAMA_BASE : RAMB_BASE, 2, i % 10), sv[i], 1'b0);
        end
        for (int i = 0; i < 20; i++)
            u_pkee_host.rd(slot(i < 10 ? RAMA_BASE : RAMB_BASE, 2, i % 10), sv[i], '1, 1'b0, v);
        u_pkee_host.wr(RAMB_LAST - 14'h3, sv[3], 1'b0);
        u_pkee_host.rd(RAMB_LAST - 14'h3, sv[3], '1, 1'b0, v);
        for (int lay = 0; lay < 3; lay++)
            for (int op = 0; op < 3; op++)
                run_op(op, lay);
        // done held while the gate is off, then shown on the pin
        check({31'h0, irq_out}, 32'h0);
        u_pkee_host.wr(STAT_OFS, '1, 1'b0);
        u_pkee_host.rd(STAT_OFS, 32'h2, 32'h7, 1'b0, v);
        u_pkee_host.wr(CFG_OFS, 32'h00030100, 1'b0);
        repeat (40) @(posedge clk_sys);
        check({31'h0, irq_out}, 32'h1);
        u_pkee_host.rd(STAT_OFS, 32'h2, 32'h7, 1'b0, v);
        // gate off with done set: pin drops, status holds
        u_pkee_host.wr(CFG_OFS, 32'h00030000, 1'b0);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq_out}, 32'h0);
        u_pkee_host.rd(STAT_OFS, 32'h2, 32'h7, 1'b0, v);
        // halt a full-width run just after it starts
        u_pkee_host.wr(CFG_OFS, 32'h00000100, 1'b0);
        u_pkee_host.wr(MODE_OFS, 32'h2, 1'b0);
        u_pkee_host.wr(CTRL_OFS, 32'h1, 1'b0);
        u_pkee_host.wr(CTRL_OFS, 32'h00010000, 1'b0);
        wait_stat(ST_BUSY, 1'b0);
        u_pkee_host.rd(STAT_OFS, 32'h4, 32'h7, 1'b0, v);
        check({31'h0, irq_out}, 32'h0);
        // empty program ends at once and clears halted
        u_pkee_host.wr(MODE_OFS, 32'h32, 1'b0);
        u_pkee_host.wr(CTRL_OFS, 32'h1, 1'b0);
        wait_stat(ST_DONE, 1'b1);
        u_pkee_host.rd(STAT_OFS, 32'h2, 32'h7, 1'b0, v);
        check({31'h0, irq_out}, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
